// [rtl/pwm_channel.sv]
// One channel: counter, double-buffered period and duty, output flip-flop.
`timescale 1ns/1ps
module pwm_channel
    import pwm_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clkEn,
    input  wire logic tick,
    pwm_chan_if.chan  ch
);
    logic [7:0] counter;
    logic [7:0] period;
    logic [7:0] duty;
    logic [7:0] periodBuf;
    logic [7:0] dutyBuf;
    logic       countDown;
    logic       flop;
    logic       run;
    logic       periodEnd;

    assign run = ch.enable && tick && clkEn;
    // Left end at period match, center end when the down count reaches zero.
    assign periodEnd = ch.centerAlign ? (countDown && counter == 8'h01)
                                      : (counter == period - 8'h01);

    // ----------------------------------------------------------------
    // Buffers and active values
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            periodBuf <= PERIOD_RST;
            dutyBuf   <= DUTY_RST;
            period    <= PERIOD_RST;
            duty      <= DUTY_RST;
        end else if (clkEn) begin
            if (ch.periodWrite) begin
                periodBuf <= ch.wrData;
                if (!ch.enable) begin
                    period <= ch.wrData;
                end
            end
            if (ch.dutyWrite) begin
                dutyBuf <= ch.wrData;
                if (!ch.enable) begin
                    duty <= ch.wrData;
                end
            end
            if (ch.counterWrite || (run && periodEnd)) begin
                period <= periodBuf;
                duty   <= dutyBuf;
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter and direction
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            counter   <= COUNT_ZERO;
            countDown <= 1'b0;
        end else if (clkEn) begin
            if (ch.counterWrite) begin
                counter   <= COUNT_ZERO;
                countDown <= 1'b0;
            end else if (run) begin
                if (period == COUNT_ZERO) begin
                    counter   <= COUNT_ZERO;
                    countDown <= 1'b0;
                end else if (!ch.centerAlign) begin
                    countDown <= 1'b0;
                    // Counts 0 .. period-1 then wraps.
                    counter <= periodEnd ? COUNT_ZERO : counter + 8'h01;
                end else if (!countDown) begin
                    if (counter + 8'h01 >= period) begin
                        countDown <= 1'b1;
                    end
                    counter <= counter + 8'h01;
                end else begin
                    counter <= counter - 8'h01;
                    if (counter == 8'h01) begin
                        countDown <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Output flip-flop (high means "past duty match")
    // ----------------------------------------------------------------
    // The flop is derived from the next counter position so that the
    // waveform level matches the counter in the same cycle.
    logic [7:0] nextCount;
    always_comb begin
        nextCount = counter;
        if (ch.counterWrite || period == COUNT_ZERO) begin
            nextCount = COUNT_ZERO;
        end else if (run) begin
            if (!ch.centerAlign) begin
                nextCount = periodEnd ? COUNT_ZERO : counter + 8'h01;
            end else if (!countDown) begin
                nextCount = counter + 8'h01;
            end else begin
                nextCount = counter - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flop <= 1'b0;
        end else if (clkEn) begin
            if (ch.counterWrite) begin
                flop <= 1'b0;
            end else if (run && !ch.centerAlign && periodEnd) begin
                flop <= 1'b0;
            end else if (run && nextCount == duty) begin
                flop <= ~flop;
            end else if (run && ch.centerAlign && nextCount == COUNT_ZERO) begin
                flop <= 1'b0;
            end
        end
    end

    // Boundary cases override the toggle flop so the level is steady.
    always_comb begin
        if (period == COUNT_ZERO) begin
            ch.wave = ch.polarity;
        end else if (duty == COUNT_ZERO) begin
            ch.wave = ~ch.polarity;
        end else if (duty >= period) begin
            ch.wave = ch.polarity;
        end else begin
            ch.wave = ch.polarity ^ flop;
        end
    end

    assign ch.counter = counter;

endmodule : pwm_channel

// [rtl/pwm_pkg.sv]
// Package with register map, widths and reset values of the waveform generator.
package pwm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_ENABLE   = 12'h000;
    localparam logic [11:0] ADDR_POLARITY = 12'h004;
    localparam logic [11:0] ADDR_CONTROL  = 12'h008;
    localparam logic [11:0] ADDR_CHAN0    = 12'h010;
    localparam logic [11:0] CHAN_STRIDE   = 12'h010;
    localparam logic [3:0]  SUB_COUNTER   = 4'h0;
    localparam logic [3:0]  SUB_PERIOD    = 4'h4;
    localparam logic [3:0]  SUB_DUTY      = 4'h8;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int          CNT_W       = 8;
    localparam logic [7:0]  COUNT_ZERO  = 8'h00;
    localparam logic [7:0]  PERIOD_RST  = 8'hFF;
    localparam logic [7:0]  DUTY_RST    = 8'hFF;
    localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

endpackage : pwm_pkg

// [rtl/pwm_chan_if.sv]
// Interface carrying one channel's controls and state between top and channel.
`timescale 1ns/1ps
interface pwm_chan_if;
    logic       enable;
    logic       centerAlign;
    logic       polarity;
    logic       counterWrite;
    logic       periodWrite;
    logic       dutyWrite;
    logic [7:0] wrData;
    logic [7:0] counter;
    logic       wave;

    modport top  (output enable, centerAlign, polarity, counterWrite, periodWrite,
                  dutyWrite, wrData, input counter, wave);
    modport chan (input enable, centerAlign, polarity, counterWrite, periodWrite,
                  dutyWrite, wrData, output counter, wave);
endinterface : pwm_chan_if

// [rtl/pwm_channel_waveform_gen.sv]
// Top of the multi-channel 8-bit waveform generator with its APB register file.
`timescale 1ns/1ps
// Overview of operation
// - Alignment select bit 0 gives left-aligned, 1 gives center-aligned output.
// - Left-aligned counter counts only upward, once per channel tick.
// - Counter equal to duty toggles the output flip-flop.
// - Left-aligned period match clears counter and flop, loads buffered values.
// - Left-aligned counter runs zero to period minus one.
// - Polarity 0 high time is period minus duty; polarity 1 is duty.
// - Center-aligned counter counts up and down, forced up at zero.
// - Center-aligned period match turns counting down without clearing.
// - Down count meeting duty toggles the flop a second time.
// - Down count reaching zero turns up and loads buffered values.
// - Center-aligned effective period equals twice the period value.
// - Zero duty with nonzero period: low for polarity 1, high for 0.
// - Zero period holds counter at zero; output equals polarity.
// - Duty at or above period with polarity 1 keeps output high.
// - Reset sets every counter to count upward.
// - Reset disables all channels; no counter advances.
// - The block raises no interrupts.
// - Disabled channel holds its counter; re-enable resumes from it.
// - Counter write clears it, counts up, loads buffers, resets output.
// - Disabled channel writes period and duty to buffer and active value.
// - Polarity set starts high, drops at duty; cleared starts low.
module pwm_channel_waveform_gen
    import pwm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              clkEn,
    input  wire logic [NUM_CH-1:0] chanTick,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    output logic [NUM_CH-1:0]      waveform_output
);
    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] channel_enable;
    logic [NUM_CH-1:0] start_polarity;
    logic [NUM_CH-1:0] center_align_select;
    logic [NUM_CH-1:0] wave;
    logic [7:0]        counts [NUM_CH];
    logic              setup;
    logic              doWrite;
    logic [31:0]       next_prdata;
    logic              next_err;

    // Answer in the access cycle: pready registered high during setup.
    assign setup   = psel && !penable;
    assign doWrite = psel && penable && pready && pwrite;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            channel_enable      <= '0;
            start_polarity      <= '0;
            center_align_select <= '0;
        end else if (clkEn && doWrite) begin
            if (paddr == ADDR_ENABLE) begin
                channel_enable <= pwdata[NUM_CH-1:0];
            end else if (paddr == ADDR_POLARITY) begin
                start_polarity <= pwdata[NUM_CH-1:0];
            end else if (paddr == ADDR_CONTROL) begin
                center_align_select <= pwdata[NUM_CH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [11:0] BASE = ADDR_CHAN0 + 12'(i) * CHAN_STRIDE;
        pwm_chan_if chIf ();
        logic       hit;
        assign hit                = doWrite && paddr[11:4] == BASE[11:4];
        assign chIf.enable        = channel_enable[i];
        assign chIf.centerAlign   = center_align_select[i];
        assign chIf.polarity      = start_polarity[i];
        assign chIf.wrData        = pwdata[7:0];
        assign chIf.counterWrite  = hit && paddr[3:0] == SUB_COUNTER;
        assign chIf.periodWrite   = hit && paddr[3:0] == SUB_PERIOD;
        assign chIf.dutyWrite     = hit && paddr[3:0] == SUB_DUTY;
        assign counts[i]          = chIf.counter;
        assign wave[i]            = chIf.wave;
        pwm_channel u_chan (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .clkEn   (clkEn),
            .tick    (chanTick[i]),
            .ch      (chIf)
        );
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        next_prdata = READ_ZERO;
        next_err    = 1'b1;
        if (paddr == ADDR_ENABLE) begin
            next_prdata[NUM_CH-1:0] = channel_enable;
            next_err = 1'b0;
        end else if (paddr == ADDR_POLARITY) begin
            next_prdata[NUM_CH-1:0] = start_polarity;
            next_err = 1'b0;
        end else if (paddr == ADDR_CONTROL) begin
            next_prdata[NUM_CH-1:0] = center_align_select;
            next_err = 1'b0;
        end
        for (int k = 0; k < NUM_CH; k++) begin
            if (paddr == ADDR_CHAN0 + 12'(k) * CHAN_STRIDE + 12'(SUB_COUNTER)) begin
                next_prdata[7:0] = counts[k];
                next_err = 1'b0;
            end else if (paddr[11:4] == 8'(({4'h0, ADDR_CHAN0} + k * 16) >> 4)
                         && (paddr[3:0] == SUB_PERIOD || paddr[3:0] == SUB_DUTY)) begin
                next_err = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= READ_ZERO;
        end else if (clkEn) begin
            pready  <= setup;
            pslverr <= setup && next_err;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // No interrupt output exists.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            waveform_output <= '0;
        end else if (clkEn) begin
            waveform_output <= wave;
        end
    end

endmodule : pwm_channel_waveform_gen

// [tb/pwm_props.sv]
// Checker of bus answers and boundary levels of the waveform generator.
`timescale 1ns/1ps
module pwm_props
    import pwm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              clkEn,
    input wire logic [NUM_CH-1:0] chanTick,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    input wire logic [NUM_CH-1:0] waveform_output
);
    // ----------------------------------------------------------------
    // Shadow of channel 0, trusted only after writes made while disabled
    // ----------------------------------------------------------------
    logic       wr;
    logic       en;
    logic       pol;
    logic       known;
    logic       ok;
    logic [1:0] quiet;
    logic [7:0] perV;
    logic [7:0] dutyV;
    assign wr = psel && penable && pready && pwrite;
    assign ok = quiet == 2'h3 && known;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {en, pol, quiet, known, perV, dutyV} <= {4'h0, 1'b1, 16'hFFFF};
        end else begin
            quiet <= wr ? 2'h0 : quiet + 2'(quiet != 2'h3);
            if (wr && paddr == ADDR_ENABLE) en <= pwdata[0];
            if (wr && paddr == ADDR_POLARITY) pol <= pwdata[0];
            if (wr && paddr == 12'h014) {known, perV} <= {known && !en, pwdata[7:0]};
            if (wr && paddr == 12'h018) {known, dutyV} <= {known && !en, pwdata[7:0]};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_ready_setup: assert property (psel && !penable && clkEn |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready && clkEn |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready && psel && paddr == 12'hFF0 |-> pslverr
        && (pwrite || prdata == READ_ZERO)) else $error("unmapped access not refused");
    a_upper_zero: assert property (pready && !pwrite && paddr == ADDR_ENABLE |-> !pslverr
        && (prdata >> NUM_CH) == READ_ZERO) else $error("enable read wrong");
    a_hold_disabled: assert property (quiet == 2'h3 && !en |-> $stable(waveform_output[0]))
        else $error("disabled output moved");
    a_no_period: assert property (ok && perV == 8'h00 |-> waveform_output[0] == pol)
        else $error("zero period level wrong");
    a_no_duty: assert property (ok && perV != 8'h00 && dutyV == 8'h00
        |-> waveform_output[0] == !pol) else $error("zero duty level wrong");
    a_full_duty: assert property (ok && perV != 8'h00 && dutyV >= perV && pol
        |-> waveform_output[0]) else $error("full duty not high");
endmodule : pwm_props
bind pwm_channel_waveform_gen pwm_props #(.NUM_CH(NUM_CH)) pwm_props_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .chanTick(chanTick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .waveform_output(waveform_output));

// [tb/pwm_load.sv]
// Load model on the waveform pins: counts high cycles and level changes.
`timescale 1ns/1ps
module pwm_load #(
    parameter int NUM_CH = 2
) (
    input  wire logic              ref_clk,
    input  wire logic              gate,
    input  wire logic [NUM_CH-1:0] wave,
    output logic                   done,
    output logic [NUM_CH-1:0][7:0] high,
    output logic [NUM_CH-1:0][7:0] edges
);
    logic              wasGate;
    logic [NUM_CH-1:0] last;
    // Counts hold for the one cycle after the window so they can be read.
    assign done = wasGate && !gate;
    always_ff @(posedge ref_clk) begin
        wasGate <= gate;
        last <= wave;
        for (int i = 0; i < NUM_CH; i++) begin
            if (!gate && !wasGate) begin
                high[i] <= 8'h00;
                edges[i] <= 8'h00;
            end else if (gate) begin
                high[i] <= high[i] + 8'(wave[i]);
                edges[i] <= edges[i] + 8'(wave[i] ^ last[i]);
            end
        end
    end
endmodule : pwm_load

// [tb/pwm_channel_waveform_gen_bench.sv]
// Self-checking bench of the waveform generator with its load model.
`timescale 1ns/1ps
module pwm_channel_waveform_gen_bench
    import pwm_pkg::*;
;
    localparam int NUM_CH = 2;
    localparam int LIMIT  = 20000;
    logic ref_clk, rstn, clkEn, psel, penable, pwrite, pready, pslverr, gate, done;
    logic [NUM_CH-1:0]      chanTick, wave, manTick;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata;
    logic [NUM_CH-1:0][7:0] high, edges;
    logic [1:0]             tickMode;
    logic [7:0]             dv;
    logic [32:0]            rdQ[$];
    logic [31:0]            msQ[$];
    int                     errors, testsRun, cycles;

    pwm_channel_waveform_gen #(.NUM_CH(NUM_CH)) pwm_channel_waveform_gen_inst (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .chanTick(chanTick), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .waveform_output(wave));
    pwm_load #(.NUM_CH(NUM_CH)) pwm_load_inst (
        .ref_clk(ref_clk), .gate(gate), .wave(wave), .done(done), .high(high), .edges(edges));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Random ticks keep disabled channels under pressure between tests.
    always @(posedge ref_clk) begin
        chanTick <= tickMode == 2'h0 ? NUM_CH'($urandom) : (tickMode == 2'h1 ? '1 : manTick);
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // Result watcher
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
            check({pslverr, prdata}, rdQ.pop_front());
        if (done === 1'b1 && msQ.size() > 0)
            check({1'b0, high[0], edges[0], high[1], edges[1]}, {1'b0, msQ.pop_front()});
    end

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        if (rdQ.size() + msQ.size() > 0) begin
            errors++;
            $display("ERROR %0t: %0d expected results never seen", $time, rdQ.size() + msQ.size());
        end
        $display("comparisons %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rdQ.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    function automatic logic [11:0] ca(input int i, input logic [3:0] s);
        return ADDR_CHAN0 + CHAN_STRIDE * 12'(i) + {8'h00, s};
    endfunction : ca
    task automatic pulse(input int n);
        manTick <= NUM_CH'(1);
        repeat (n) @(posedge ref_clk);
        manTick <= '0;
        repeat (2) @(posedge ref_clk);
    endtask : pulse
    task automatic run_case(input logic p, input logic [7:0] per, input logic [7:0] d);
        logic [7:0] h;
        logic [7:0] e;
        h = per == 8'h00 ? {8{p}} & 8'h28 : d == 8'h00 ? {8{!p}} & 8'h28 : d >= per ? 8'h28
            : p ? 8'h0A * d : 8'h0A * (per - d);
        e = (per == 8'h00 || d == 8'h00 || d >= per) ? 8'h00 : 8'h14;
        apb(1'b1, ADDR_ENABLE, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h2);
        apb(1'b1, ADDR_POLARITY, {30'h0, p, p});
        for (int i = 0; i < NUM_CH; i++) begin
            apb(1'b1, ca(i, SUB_PERIOD), {24'h0, per});
            apb(1'b1, ca(i, SUB_DUTY), {24'h0, d});
            apb(1'b1, ca(i, SUB_COUNTER), 32'h0);
        end
        apb(1'b1, ADDR_ENABLE, 32'h3);
        tickMode <= 2'h1;
        repeat (16) @(posedge ref_clk);
        msQ.push_back({h, e, h, e >> 1});
        gate <= 1'b1;
        repeat (40) @(posedge ref_clk);
        gate <= 1'b0;
        repeat (2) @(posedge ref_clk);
        tickMode <= 2'h0;
        $display("test pol %0d period %0d duty %0d done", p, per, d);
    endtask : run_case

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, gate} = '0;
        clkEn    = 1'b1;
        manTick  = '0;
        tickMode = 2'h0;
        errors   = 0;
        testsRun = 0;
        cycles   = 0;
        void'($urandom(32'hE3C2));
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(ca(0, SUB_COUNTER), 33'h0);
        rd(ADDR_ENABLE, 33'h0);
        rd(12'hFF0, {1'b1, 32'h0});
        $display("test reset and map done");
        for (int k = 0; k < 7; k++) begin
            dv = 8'($urandom_range(3, 1));
            run_case(7'b1010110 >> k, (k == 4 || k == 5) ? 8'h00 : 8'h04,
                (k == 2 || k == 3) ? 8'h00 : dv + {k == 6, 2'h0});
        end
        apb(1'b1, ADDR_ENABLE, 32'h0);
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ca(0, SUB_PERIOD), 32'h8);
        apb(1'b1, ca(0, SUB_COUNTER), 32'hA5);
        rd(ca(0, SUB_COUNTER), 33'h0);
        for (int j = 3; j > 1; j--) begin
            tickMode <= 2'h2;
            apb(1'b1, ADDR_ENABLE, 32'h1);
            pulse(j);
            apb(1'b1, ADDR_ENABLE, 32'h0);
            tickMode <= 2'h0;
            repeat (20) @(posedge ref_clk);
            rd(ca(0, SUB_COUNTER), j == 3 ? 33'h3 : 33'h5);
        end
        $display("test hold and resume done");
        // A cleared flop shows the start level; only a direct load of zero duty can drop it.
        apb(1'b1, ca(0, SUB_COUNTER), 32'h0);
        apb(1'b1, ca(0, SUB_DUTY), 32'h0);
        repeat (2) @(posedge ref_clk);
        msQ.push_back({8'h00, 8'h00, 8'h28, 8'h00});
        gate <= 1'b1;
        repeat (40) @(posedge ref_clk);
        gate <= 1'b0;
        repeat (2) @(posedge ref_clk);
        $display("test direct load while disabled done");
        give_verdict();
    end
endmodule : pwm_channel_waveform_gen_bench
